// [hw/system_timebase_pll_config.sv]
// Control registers of the integer-N system timebase synthesizer
//
// Function
// - Feedback ratio is the 8-bit register value, valid four to 255.
// - Prescaler divides by two to the power of config bits two to one.
// - Config bit zero set doubles the synthesizer input reference.
// - Config bit three selects crystal path; zero, the default, is direct.
// - Output is input times feedback over prescale; doubler makes prescale half.
// - Synthesizer is integer-N with integrated loop filter and oscillator.
// - Status bit zero reports synthesizer lock, one when locked.
`timescale 1ns/1ps
`default_nettype none

module system_timebase_pll_config (
    input wire logic mclk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic [17:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire timebase_pkg::synth_stat_t core_status,
    output timebase_pkg::synth_cfg_t core_cfg,
    output logic [4:0] timebase_mult_x2
);

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    logic [15:0] idx;
    logic access;
    logic wr_en;
    logic done_q;
    logic [7:0] wbyte;

    assign idx = avs_address[17:2];
    assign access = (avs_read | avs_write) & ~done_q;
    // Byte lane zero carries every register
    assign wr_en = clk_en & avs_write & ~done_q & avs_byteenable[0];
    assign wbyte = avs_writedata[7:0];

    // ------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------
    // Index falls in the five reference bytes
    function automatic logic is_ref_idx(input logic [15:0] i);
        return (i >= timebase_pkg::REF_FREQ_IDX0) && (i <= timebase_pkg::REF_FREQ_IDX4);
    endfunction

    // Bit position of a reference byte, least significant first
    function automatic logic [5:0] ref_bit_pos(input logic [15:0] i);
        logic [15:0] offs;
        offs = i - timebase_pkg::REF_FREQ_IDX0;
        return {offs[2:0], 3'h0};
    endfunction

    // Prescale ratio in halves of a division step
    function automatic logic [4:0] prescale_halves(input logic dbl, input logic [1:0] sel);
        logic [4:0] base;
        base = dbl ? 5'h01 : 5'h02;
        return 5'(base << sel);
    endfunction

    // Feedback ratio raised to the lowest legal value
    function automatic logic [7:0] legal_ratio(input logic [7:0] r);
        return (r < timebase_pkg::FEEDBACK_RATIO_MIN) ? timebase_pkg::FEEDBACK_RATIO_MIN : r;
    endfunction

    // ------------------------------------------------------------
    // Status synchroniser (core runs on its own analogue clock)
    // ------------------------------------------------------------
    timebase_pkg::synth_stat_t stat_meta_q;
    timebase_pkg::synth_stat_t stat_q;

    always_ff @(posedge mclk) begin
        if (rst) begin
            stat_meta_q <= '0;
            stat_q <= '0;
        end else if (clk_en) begin
            stat_meta_q <= core_status;
            stat_q <= stat_meta_q;
        end
    end

    // ------------------------------------------------------------
    // Staged registers (take effect on update)
    // ------------------------------------------------------------
    logic [7:0] fb_stage_q;
    logic [7:0] cfg_stage_q;
    logic [39:0] ref_stage_q;
    logic cal_stage_q;
    logic update;

    // Update strobe: write one to bit zero of the update index
    assign update = wr_en & (idx == timebase_pkg::UPDATE_IDX) & wbyte[timebase_pkg::UPDATE_BIT];

    always_ff @(posedge mclk) begin
        if (rst) begin
            fb_stage_q <= timebase_pkg::FEEDBACK_RATIO_RST;
        end else if (wr_en && idx == timebase_pkg::FEEDBACK_RATIO_IDX) begin
            fb_stage_q <= wbyte;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            cfg_stage_q <= timebase_pkg::INPUT_CONFIG_RST;
        end else if (wr_en && idx == timebase_pkg::INPUT_CONFIG_IDX) begin
            // Upper config bits are not stored
            cfg_stage_q <= {4'h0, wbyte[3:0]};
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            ref_stage_q <= timebase_pkg::REF_FREQ_RST;
        end else if (wr_en && is_ref_idx(idx)) begin
            ref_stage_q[ref_bit_pos(idx) +: 8] <= wbyte;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            cal_stage_q <= 1'b0;
        end else if (wr_en && idx == timebase_pkg::CAL_CONTROL_IDX) begin
            cal_stage_q <= wbyte[timebase_pkg::CAL_BIT];
        end
    end

    // ------------------------------------------------------------
    // Active settings to the core
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (rst) begin
            core_cfg <= '{feedback_ratio: timebase_pkg::FEEDBACK_RATIO_RST,
                          prescale_sel: 2'h0, doubler_en: 1'b0, xtal_path_en: 1'b0,
                          cal_request: 1'b0, ref_frequency: timebase_pkg::REF_FREQ_RST};
        end else if (clk_en && update) begin
            core_cfg.feedback_ratio <= legal_ratio(fb_stage_q);
            core_cfg.prescale_sel <=
                cfg_stage_q[timebase_pkg::PRESCALE_MSB:timebase_pkg::PRESCALE_LSB];
            core_cfg.doubler_en <= cfg_stage_q[timebase_pkg::DOUBLER_BIT];
            core_cfg.xtal_path_en <= cfg_stage_q[timebase_pkg::XTAL_PATH_BIT];
            core_cfg.cal_request <= cal_stage_q;
            core_cfg.ref_frequency <= ref_stage_q;
        end
    end

    // effective prescale, in halves: 2^J*2, or 2^J with doubler
    always_ff @(posedge mclk) begin
        if (rst) begin
            timebase_mult_x2 <= timebase_pkg::MULT_X2_RST;
        end else if (clk_en) begin
            timebase_mult_x2 <= prescale_halves(core_cfg.doubler_en, core_cfg.prescale_sel);
        end
    end

    // ------------------------------------------------------------
    // Read path and waitrequest (one wait cycle per access)
    // ------------------------------------------------------------
    logic [31:0] rdata_d;

    always_comb begin
        rdata_d = 32'h0000_0000;
        if (idx == timebase_pkg::FEEDBACK_RATIO_IDX) begin
            rdata_d[7:0] = fb_stage_q;
        end else if (idx == timebase_pkg::INPUT_CONFIG_IDX) begin
            rdata_d[7:0] = cfg_stage_q;
        end else if (is_ref_idx(idx)) begin
            rdata_d[7:0] = ref_stage_q[ref_bit_pos(idx) +: 8];
        end else if (idx == timebase_pkg::CAL_CONTROL_IDX) begin
            rdata_d[timebase_pkg::CAL_BIT] = cal_stage_q;
        end else if (idx == timebase_pkg::STATUS_IDX) begin
            rdata_d[timebase_pkg::LOCK_BIT] = stat_q.lock;
            rdata_d[timebase_pkg::CAL_BUSY_BIT] = stat_q.cal_busy;
        end
    end

    // Access marker: blocks a second accept in the answer cycle
    always_ff @(posedge mclk) begin
        if (rst) begin
            done_q <= 1'b0;
        end else if (clk_en) begin
            done_q <= access;
        end
    end

    // Read data held until the next read
    always_ff @(posedge mclk) begin
        if (rst) begin
            avs_readdata <= 32'h0000_0000;
        end else if (clk_en && avs_read && !done_q) begin
            avs_readdata <= rdata_d;
        end
    end

    // Low for one cycle after each accepted access
    always_ff @(posedge mclk) begin
        if (rst) begin
            avs_waitrequest <= 1'b1;
        end else if (clk_en) begin
            avs_waitrequest <= ~access;
        end
    end

endmodule // system_timebase_pll_config

`default_nettype wire

// [hw/timebase_pkg.sv]
// Package: register map, field layout and types of the timebase synthesizer control
package timebase_pkg;
    // Register indices (printed offsets are not all multiples of four; byte address = 4 * index)
    localparam logic [15:0] FEEDBACK_RATIO_IDX = 16'h0200;
    localparam logic [15:0] INPUT_CONFIG_IDX = 16'h0201;
    localparam logic [15:0] REF_FREQ_IDX0 = 16'h0202;
    localparam logic [15:0] REF_FREQ_IDX4 = 16'h0206;
    localparam logic [15:0] CAL_CONTROL_IDX = 16'h2000;
    localparam logic [15:0] STATUS_IDX = 16'h3001;
    localparam logic [15:0] UPDATE_IDX = 16'h000f;

    // Input config fields
    localparam int DOUBLER_BIT = 0;
    localparam int PRESCALE_LSB = 1;
    localparam int PRESCALE_MSB = 2;
    localparam int XTAL_PATH_BIT = 3;
    // Cal control, update and status fields
    localparam int CAL_BIT = 2;
    localparam int UPDATE_BIT = 0;
    localparam int LOCK_BIT = 0;
    localparam int CAL_BUSY_BIT = 2;

    // Reset values and the lowest legal feedback ratio
    localparam logic [7:0] FEEDBACK_RATIO_RST = 8'h04;
    localparam logic [7:0] INPUT_CONFIG_RST = 8'h00;
    localparam logic [39:0] REF_FREQ_RST = 40'h00_0000_0000;
    localparam logic [7:0] FEEDBACK_RATIO_MIN = 8'h04;
    localparam logic [4:0] MULT_X2_RST = 5'h02;

    // Settings driven out to the analogue synthesizer core
    typedef struct packed {
        logic [7:0] feedback_ratio;
        logic [1:0] prescale_sel;
        logic doubler_en;
        logic xtal_path_en;
        logic cal_request;
        logic [39:0] ref_frequency;
    } synth_cfg_t;

    // Status from the synthesizer core
    typedef struct packed {
        logic lock;
        logic cal_busy;
    } synth_stat_t;
endpackage

// [testbench/tb.sv]
// Self-checking bench of the timebase control registers
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic [17:0] avs_address = 18'h0_0000;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [3:0] avs_byteenable = 4'hf;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    timebase_pkg::synth_stat_t core_status = 2'h0;
    timebase_pkg::synth_cfg_t core_cfg;
    logic [4:0] timebase_mult_x2;
    logic clk_en = 1'b1;
    logic [39:0] fs;
    int num_errors = 0;
    int checked = 0;
    int cyc = 0;
    logic [31:0] seed = 32'h0000_001a;
    logic [7:0] st [7];
    logic [7:0] q;
    // -------------
    // Harness, tasks
    // -------------
    always #20 mclk = ~mclk;
    system_timebase_pll_config uut (.mclk(mclk), .rst(rst), .clk_en(clk_en),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .core_status(core_status), .core_cfg(core_cfg), .timebase_mult_x2(timebase_mult_x2));
    function automatic logic [7:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[7:0];
    endfunction
    task automatic chk(input string n, input logic [39:0] e, input logic [39:0] g);
        checked++;
        if (g !== e) begin
            num_errors++;
            $display("Error %s expected %0h seen %0h", n, e, g);
        end
    endtask
    task automatic stop_test();
        $display("checked %0d num_errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic bus(input logic w, input logic [15:0] i, input logic [7:0] d,
        input logic [3:0] be);
        avs_write <= w;
        avs_read <= !w;
        avs_address <= {i, 2'h0};
        avs_writedata <= {24'h00_0000, d};
        avs_byteenable <= be;
        do @(posedge mclk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata[7:0];
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge mclk);
        if (w && be[0] && i >= 16'h0200 && i <= 16'h0206)
            st[i - 16'h0200] = d & (i == 16'h0201 ? 8'h0f : 8'hff);
    endtask
    task automatic rdall();
        for (int i = 0; i < 7; i++) begin
            bus(1'b0, 16'h0200 + 16'(i), 8'h00, 4'hf);
            chk("reg", st[i], q);
        end
    endtask
    task automatic apply(input logic c);
        bus(1'b1, 16'h000f, 8'h01, 4'hf);
        chk("ratio", st[0] < 8'h04 ? 8'h04 : st[0], core_cfg.feedback_ratio);
        chk("prescale", st[1][2:1], core_cfg.prescale_sel);
        chk("doubler", st[1][0], core_cfg.doubler_en);
        chk("xtal", st[1][3], core_cfg.xtal_path_en);
        chk("cal", c, core_cfg.cal_request);
        chk("ref", {st[6], st[5], st[4], st[3], st[2]}, core_cfg.ref_frequency);
        chk("mult", (st[1][0] ? 5'h01 : 5'h02) << st[1][2:1], timebase_mult_x2);
    endtask
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 6000) begin
            num_errors++;
            stop_test();
        end
    end
    initial begin
        for (int i = 0; i < 7; i++) st[i] = i ? 8'h00 : 8'h04;
        repeat (20) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        chk("mult", 5'h02, timebase_mult_x2);
        bus(1'b0, 16'h0100, 8'h00, 4'hf);
        chk("unmapped", 8'h00, q);
        bus(1'b1, 16'h0200, 8'h55, 4'h0);
        rdall();
        for (int k = 0; k < 16; k++) begin
            bus(1'b1, 16'h0201, (rnd() & 8'hf0) | 8'(k), 4'hf);
            bus(1'b1, 16'h0200, k == 3 ? 8'h03 : k == 5 ? 8'hff : rnd(), 4'hf);
            for (int b = 2; b < 7; b++) bus(1'b1, 16'h0200 + 16'(b), rnd(), 4'hf);
            bus(1'b1, 16'h2000, {5'h00, k[1], 2'h0}, 4'hf);
            rdall();
            apply(k[1]);
        end
        // Freeze: a held request is not answered
        clk_en <= 1'b0;
        fork
            bus(1'b1, 16'h0200, 8'h2a, 4'hf);
            begin
                repeat (5) @(posedge mclk);
                chk("freeze", 1'b1, avs_waitrequest);
                clk_en <= 1'b1;
            end
        join
        rdall();
        // Mid-run reset
        rst <= 1'b1;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        for (int i = 0; i < 7; i++) st[i] = i ? 8'h00 : 8'h04;
        @(posedge mclk);
        chk("mult", 5'h02, timebase_mult_x2);
        chk("ratio", 8'h04, core_cfg.feedback_ratio);
        chk("xtal", 1'b0, core_cfg.xtal_path_en);
        rdall();
        core_status <= 2'h2;
        repeat (4) @(posedge mclk);
        bus(1'b0, 16'h3001, 8'h00, 4'hf);
        chk("lock", 8'h01, q);
        core_status <= 2'h1;
        repeat (4) @(posedge mclk);
        bus(1'b0, 16'h3001, 8'h00, 4'hf);
        chk("unlock", 8'h04, q);
        bus(1'b1, 16'h0201, 8'h03, 4'hf);
        bus(1'b1, 16'h0200, 8'h17, 4'hf);
        for (int b = 0; b < 5; b++)
            bus(1'b1, 16'h0202 + 16'(b), 8'(40'h00_05f5_e100 >> (8 * b)), 4'hf);
        bus(1'b1, 16'h2000, 8'h04, 4'hf);
        apply(1'b1);
        bus(1'b1, 16'h2000, 8'h00, 4'hf);
        apply(1'b0);
        fs = core_cfg.ref_frequency * core_cfg.feedback_ratio * 40'h02 / timebase_mult_x2;
        chk("fs", 40'h00_8917_3700, fs);
        stop_test();
    end
endmodule // tb
`default_nettype wire

// [testbench/timebase_checker_assertions.sv]
// Checker of the timebase control ports
`timescale 1ns/1ps
`default_nettype none
module timebase_checker (
    input wire logic mclk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic [17:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire timebase_pkg::synth_cfg_t core_cfg,
    input wire logic [4:0] timebase_mult_x2
);
    // ----------
    // Properties
    // ----------
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    wire logic acc = clk_en && avs_waitrequest && (avs_read || avs_write);
    wire logic upd = acc && avs_write && avs_writedata[0] && avs_byteenable[0]
        && avs_address[17:2] == timebase_pkg::UPDATE_IDX;
    property p_acc; acc |=> !avs_waitrequest; endproperty
    a_acc: assert property (p_acc) else $error("no answer");
    property p_back; !avs_waitrequest && clk_en |=> avs_waitrequest; endproperty
    a_back: assert property (p_back) else $error("answer too long");
    property p_idle; clk_en && avs_waitrequest && !avs_read && !avs_write |=> avs_waitrequest; endproperty
    a_idle: assert property (p_idle) else $error("answer without request");
    property p_hold; !(acc && avs_read) |=> $stable(avs_readdata); endproperty
    a_hold: assert property (p_hold) else $error("read data moved");
    property p_cfg; !upd |=> $stable(core_cfg); endproperty
    a_cfg: assert property (p_cfg) else $error("settings moved without update");
    property p_clamp; upd |=> core_cfg.feedback_ratio >= 8'h04; endproperty
    a_clamp: assert property (p_clamp) else $error("ratio below four");
    property p_mult; clk_en |=> timebase_mult_x2
        == (($past(core_cfg.doubler_en) ? 5'h01 : 5'h02) << $past(core_cfg.prescale_sel));
    endproperty
    a_mult: assert property (p_mult) else $error("prescale ratio wrong");
    property p_rst; $past(rst) |-> core_cfg.feedback_ratio == 8'h04 && core_cfg.prescale_sel == 2'h0
        && !core_cfg.doubler_en && !core_cfg.xtal_path_en; endproperty
    a_rst: assert property (p_rst) else $error("reset settings wrong");
endmodule // timebase_checker
bind system_timebase_pll_config timebase_checker chk (.mclk(mclk), .rst(rst), .clk_en(clk_en),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .core_cfg(core_cfg), .timebase_mult_x2(timebase_mult_x2));
`default_nettype wire
